// ===== src/ulc_defs.svh
// constants for the uart line control block
//
// Overview of operation
// - Divisor latch access set maps shared locations to the divisor latches.
// - Force break set holds the serial output low outside loopback; clear restores it.
// - Stick parity with parity on sends a fixed bit equal to even select.
// - Even parity select chooses even parity when set, odd when clear.
// - Stop control sends 1.5 stops for five bits, 2 otherwise; else 1.
// - The receiver checks only the first stop bit of each character.
// - Word length field picks five, six, seven or eight data bits.
// - Input select routes the receiver from the LIN input or pin five.
// - Loopback mode is enabled by input control bit 4; pin held high.
// - Line status is read only and resets to 0x60.
// - Transmit, receive and divisor low share one address.
// - Baud is clock over two to the divider, 16, 2 and divisor.
`ifndef ULC_DEFS_SVH
`define ULC_DEFS_SVH

// register byte addresses
`define ULC_ADDR_DATA 32'hFFFF0700
`define ULC_ADDR_IER 32'hFFFF0704
`define ULC_ADDR_LCR 32'hFFFF070C
`define ULC_ADDR_ICR 32'hFFFF0710
`define ULC_ADDR_STAT 32'hFFFF0714
`define ULC_ADDR_CDIV 32'hFFFF0718

// line control fields
`define ULC_LC_DIVISOR_LATCH_ACCESS 7
`define ULC_LC_BRK 6
// input control fields
`define ULC_IC_SEL_HI 7
`define ULC_IC_SEL_LO 6
`define ULC_IC_LOOP 4
`define ULC_IC_MASK 8'hD0
`define ULC_SEL_LIN 2'h0
`define ULC_SEL_GP5 2'h2
`define ULC_IER_MASK 4'hF

// reset values
`define ULC_LCR_RESET 8'h00
`define ULC_ICR_RESET 8'h00
`define ULC_STAT_RESET 8'h60

// oversampling and stop lengths, in 16x ticks
`define ULC_TICK_LAST 6'h0F
`define ULC_TICK_HALF 4'h7
`define ULC_STOP_ONE 6'h10
`define ULC_STOP_ONEHALF 6'h18
`define ULC_STOP_TWO 6'h20

`endif

// ===== src/ulc_pkg.sv
// types shared by the uart line control modules
package ulc_pkg;

	// framing fields in line control bit order 5..0
	typedef struct packed
	{
		logic sp;
		logic even_parity_select;
		logic parity_enable;
		logic stb;
		logic [1:0] word_length_select;
	} ulc_frame_t;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_DATA = 3'h3,
		ST_PAR = 3'h2,
		ST_STOP = 3'h6
	} ulc_st_t;

	// parity bit that goes with a character under a framing
	function automatic logic ulc_parity(input logic [7:0] d,
		input ulc_frame_t c);
		logic [7:0] m;
		m = d;
		unique case (c.word_length_select)
			2'h0: m = d & 8'h1F;
			2'h1: m = d & 8'h3F;
			2'h2: m = d & 8'h7F;
			2'h3: m = d;
		endcase
		if (c.sp)
			return c.even_parity_select;
		return c.even_parity_select ? ^m : ~^m;
	endfunction

endpackage

// ===== src/ulc_rx_if.sv
// link between the control core and the receiver
`timescale 1ns/1ps
interface ulc_rx_if;
	import ulc_pkg::*;
	logic tick;
	logic rx_in;
	ulc_frame_t cfg;
	logic done;
	logic [7:0] data;
	logic perr;
	logic ferr;
	logic force_break;
	modport ctl (output tick, rx_in, cfg, input done, data, perr, ferr, force_break);
	modport rx (input tick, rx_in, cfg, output done, data, perr, ferr, force_break);
endinterface

// ===== src/ulc_rx.sv
// serial receiver with 16x oversampling
`timescale 1ns/1ps
`include "ulc_defs.svh"
module ulc_rx
	import ulc_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control side
	ulc_rx_if.rx rif
);

	ulc_st_t st_r;
	logic [3:0] cnt_r;
	logic [2:0] idx_r;
	logic [7:0] sh_r;
	logic zero_r;
	ulc_frame_t cfg_r;
	logic done_r;
	logic [7:0] data_r;
	logic perr_r;
	logic ferr_r;
	logic brk_r;
	logic bit_end;
	logic [2:0] last_idx;

	assign bit_end = rif.tick && (cnt_r == `ULC_TICK_LAST);
	assign last_idx = {1'b0, cfg_r.word_length_select} + 3'h4;

	// frame sequencer; framing caught at the start edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= ST_IDLE;
			cnt_r <= 4'h0;
			idx_r <= 3'h0;
			sh_r <= 8'h00;
			zero_r <= 1'b0;
			cfg_r <= '0;
		end
		else
		begin
			unique case (st_r)
				ST_IDLE:
					if (!rif.rx_in)
					begin
						st_r <= ST_START;
						cnt_r <= 4'h0;
						cfg_r <= rif.cfg;
					end
				ST_START:
					if (rif.tick)
					begin
						if (cnt_r == `ULC_TICK_HALF)
						begin
							// a glitch shorter than half a bit is dropped
							st_r <= rif.rx_in ? ST_IDLE : ST_DATA;
							cnt_r <= 4'h0;
							idx_r <= 3'h0;
							sh_r <= 8'h00;
							zero_r <= 1'b1;
						end
						else
							cnt_r <= cnt_r + 4'h1;
					end
				ST_DATA:
					if (rif.tick)
					begin
						cnt_r <= cnt_r + 4'h1;
						if (bit_end)
						begin
							sh_r[idx_r] <= rif.rx_in;
							zero_r <= zero_r & ~rif.rx_in;
							idx_r <= idx_r + 3'h1;
							if (idx_r == last_idx)
								st_r <= cfg_r.parity_enable ? ST_PAR : ST_STOP;
						end
					end
				ST_PAR:
					if (rif.tick)
					begin
						cnt_r <= cnt_r + 4'h1;
						if (bit_end)
							st_r <= ST_STOP;
					end
				ST_STOP:
					if (rif.tick)
					begin
						cnt_r <= cnt_r + 4'h1;
						if (bit_end)
							st_r <= ST_IDLE;
					end
				default:
					st_r <= ST_IDLE;
			endcase
		end
	end

	// results: parity judged at its bit, framing on the first stop only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			done_r <= 1'b0;
			data_r <= 8'h00;
			perr_r <= 1'b0;
			ferr_r <= 1'b0;
			brk_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			if (st_r == ST_START && rif.tick && cnt_r == `ULC_TICK_HALF)
				perr_r <= 1'b0;
			if (st_r == ST_PAR && bit_end)
				perr_r <= rif.rx_in != ulc_parity(sh_r, cfg_r);
			if (st_r == ST_STOP && bit_end)
			begin
				done_r <= 1'b1;
				data_r <= sh_r;
				ferr_r <= !rif.rx_in;
				brk_r <= !rif.rx_in && zero_r;
			end
		end
	end

	assign rif.done = done_r;
	assign rif.data = data_r;
	assign rif.perr = perr_r;
	assign rif.ferr = ferr_r;
	assign rif.force_break = brk_r;

	// one stop bit closes the frame
	chk_rx_one_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_r == ST_STOP && bit_end) |=> (st_r == ST_IDLE && done_r))
		else $error("receiver did not close frame after first stop");

endmodule

// ===== src/ulc_top.sv
// uart line control core with AHB-Lite register slave
`timescale 1ns/1ps
`include "ulc_defs.svh"
module ulc_top
	import ulc_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// serial pins
	input wire logic lin_rxd,
	input wire logic general_pin_five,
	output logic txd
);

	// ****************************************
	// bus slave
	// ****************************************
	logic wr_pend_r;
	logic rd_pend_r;
	logic [31:0] addr_r;
	logic [31:0] hrdata_r;
	logic [7:0] rd_byte;
	logic wr_en;
	logic rd_en;
	logic addr_phase;

	assign addr_phase = hsel && hready && htrans[1];
	assign wr_en = wr_pend_r;
	assign rd_en = rd_pend_r;
	// reads take one wait state so the data come out of a register
	assign hreadyout = !rd_pend_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// address phase capture; hsize is word only and not decoded
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 32'h00000000;
		end
		else
		begin
			wr_pend_r <= addr_phase && hwrite;
			rd_pend_r <= addr_phase && !hwrite;
			if (addr_phase)
				addr_r <= haddr;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] lcr_r;
	logic [7:0] icr_r;
	logic [7:0] dll_r;
	logic [7:0] dlh_r;
	logic [3:0] ier_r;
	logic [2:0] cdiv_r;
	logic [7:0] thr_r;
	logic thr_full_r;
	logic [7:0] rbr_r;
	logic dr_r;
	logic oe_r;
	logic pe_r;
	logic fe_r;
	logic bi_r;
	logic divisor_latch_access;
	logic loop;
	logic [1:0] in_sel;
	logic [7:0] stat;
	logic temt;
	logic tx_load;
	logic wr_data;
	logic rd_data;
	logic rd_stat;
	ulc_st_t tx_st_r;

	assign divisor_latch_access = lcr_r[`ULC_LC_DIVISOR_LATCH_ACCESS];
	assign loop = icr_r[`ULC_IC_LOOP];
	assign in_sel = icr_r[`ULC_IC_SEL_HI:`ULC_IC_SEL_LO];
	assign temt = !thr_full_r && tx_st_r == ST_IDLE;
	assign stat = {1'b0, temt, !thr_full_r, bi_r, fe_r, pe_r, oe_r, dr_r};
	assign wr_data = wr_en && addr_r == `ULC_ADDR_DATA && !divisor_latch_access;
	assign rd_data = rd_en && addr_r == `ULC_ADDR_DATA && !divisor_latch_access;
	assign rd_stat = rd_en && addr_r == `ULC_ADDR_STAT;

	// software written configuration
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lcr_r <= `ULC_LCR_RESET;
			icr_r <= `ULC_ICR_RESET;
			dll_r <= 8'h00;
			dlh_r <= 8'h00;
			ier_r <= 4'h0;
			cdiv_r <= 3'h0;
		end
		else if (wr_en)
		begin
			unique case (addr_r)
				`ULC_ADDR_DATA:
					if (divisor_latch_access)
						dll_r <= hwdata[7:0];
				`ULC_ADDR_IER:
					if (divisor_latch_access)
						dlh_r <= hwdata[7:0];
					else
						ier_r <= hwdata[3:0] & `ULC_IER_MASK;
				`ULC_ADDR_LCR: lcr_r <= hwdata[7:0];
				`ULC_ADDR_ICR: icr_r <= hwdata[7:0] & `ULC_IC_MASK;
				`ULC_ADDR_CDIV: cdiv_r <= hwdata[2:0];
				default: ; // status and unmapped writes fall away
			endcase
		end
	end

	// transmit holding: a new character wins over the consume
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			thr_r <= 8'h00;
			thr_full_r <= 1'b0;
		end
		else if (wr_data)
		begin
			thr_r <= hwdata[7:0];
			thr_full_r <= 1'b1;
		end
		else if (tx_load)
			thr_full_r <= 1'b0;
	end

	ulc_rx_if rif ();

	// receive holding and line status; a setting event wins over a clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rbr_r <= 8'h00;
			dr_r <= 1'b0;
			oe_r <= 1'b0;
			pe_r <= 1'b0;
			fe_r <= 1'b0;
			bi_r <= 1'b0;
		end
		else
		begin
			if (rif.done)
				rbr_r <= rif.data;
			if (rif.done)
				dr_r <= 1'b1;
			else if (rd_data)
				dr_r <= 1'b0;
			if (rif.done && dr_r && !rd_data)
				oe_r <= 1'b1;
			else if (rd_stat)
				oe_r <= 1'b0;
			if (rif.done && rif.perr)
				pe_r <= 1'b1;
			else if (rd_stat)
				pe_r <= 1'b0;
			if (rif.done && rif.ferr)
				fe_r <= 1'b1;
			else if (rd_stat)
				fe_r <= 1'b0;
			if (rif.done && rif.force_break)
				bi_r <= 1'b1;
			else if (rd_stat)
				bi_r <= 1'b0;
		end
	end

	// read mux, banked by divisor latch access
	always_comb
	begin
		rd_byte = 8'h00;
		unique case (addr_r)
			`ULC_ADDR_DATA: rd_byte = divisor_latch_access ? dll_r : rbr_r;
			`ULC_ADDR_IER: rd_byte = divisor_latch_access ? dlh_r : {4'h0, ier_r};
			`ULC_ADDR_LCR: rd_byte = lcr_r;
			`ULC_ADDR_ICR: rd_byte = icr_r;
			`ULC_ADDR_STAT: rd_byte = stat;
			`ULC_ADDR_CDIV: rd_byte = {5'h00, cdiv_r};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_r <= 32'h00000000;
		else if (rd_en)
			hrdata_r <= {24'h000000, rd_byte};
	end

	// ****************************************
	// baud tick at 16x the bit rate
	// ****************************************
	logic [23:0] div_cnt_r;
	logic [23:0] div_reload;
	logic [15:0] dl;
	logic tick;

	// a zero divisor would stall the line, so it counts as one
	assign dl = ({dlh_r, dll_r} == 16'h0000) ? 16'h0001 : {dlh_r, dll_r};
	assign div_reload = (({8'h00, dl} << cdiv_r) << 1) - 24'h000001;
	assign tick = div_cnt_r == 24'h000000;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			div_cnt_r <= 24'h000000;
		else if (tick)
			div_cnt_r <= div_reload;
		else
			div_cnt_r <= div_cnt_r - 24'h000001;
	end

	// ****************************************
	// transmitter
	// ****************************************
	logic [5:0] tx_cnt_r;
	logic [2:0] tx_idx_r;
	logic [7:0] tx_sh_r;
	ulc_frame_t tx_cfg_r;
	logic tx_par_r;
	logic tx_ser_r;
	logic [5:0] stop_len_r;
	logic [5:0] stop_len;
	logic tx_bit_end;
	ulc_frame_t lcr_frame;

	assign lcr_frame = lcr_r[5:0];
	assign tx_load = tx_st_r == ST_IDLE && thr_full_r;
	assign tx_bit_end = tick && tx_cnt_r == `ULC_TICK_LAST;
	assign stop_len = !lcr_frame.stb ? `ULC_STOP_ONE :
		(lcr_frame.word_length_select == 2'h0 ? `ULC_STOP_ONEHALF : `ULC_STOP_TWO);

	// character sequencer; framing is latched per character
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_st_r <= ST_IDLE;
			tx_cnt_r <= 6'h00;
			tx_idx_r <= 3'h0;
			tx_sh_r <= 8'h00;
			tx_cfg_r <= '0;
			tx_par_r <= 1'b0;
			tx_ser_r <= 1'b1;
			stop_len_r <= `ULC_STOP_ONE;
		end
		else
		begin
			if (tick)
				tx_cnt_r <= tx_cnt_r + 6'h01;
			unique case (tx_st_r)
				ST_IDLE:
					if (thr_full_r)
					begin
						tx_st_r <= ST_START;
						tx_cnt_r <= 6'h00;
						tx_sh_r <= thr_r;
						tx_cfg_r <= lcr_frame;
						tx_par_r <= ulc_parity(thr_r, lcr_frame);
						stop_len_r <= stop_len;
						tx_ser_r <= 1'b0;
					end
				ST_START:
					if (tx_bit_end)
					begin
						tx_st_r <= ST_DATA;
						tx_cnt_r <= 6'h00;
						tx_idx_r <= 3'h0;
						tx_ser_r <= tx_sh_r[0];
					end
				ST_DATA:
					if (tx_bit_end)
					begin
						tx_cnt_r <= 6'h00;
						tx_idx_r <= tx_idx_r + 3'h1;
						tx_sh_r <= {1'b0, tx_sh_r[7:1]};
						tx_ser_r <= tx_sh_r[1];
						// last data bit set by word length
						if (tx_idx_r == {1'b0, tx_cfg_r.word_length_select} + 3'h4)
						begin
							tx_st_r <= tx_cfg_r.parity_enable ? ST_PAR : ST_STOP;
							tx_ser_r <= tx_cfg_r.parity_enable ? tx_par_r : 1'b1;
						end
					end
				ST_PAR:
					if (tx_bit_end)
					begin
						tx_st_r <= ST_STOP;
						tx_cnt_r <= 6'h00;
						tx_ser_r <= 1'b1;
					end
				ST_STOP:
					if (tick && tx_cnt_r == stop_len_r - 6'h01)
						tx_st_r <= ST_IDLE;
				default:
					tx_st_r <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// pins and receive routing
	// ****************************************
	logic [1:0] pin_s1_r;
	logic [1:0] pin_s2_r;
	logic [1:0] pins;
	logic ext_rx;
	logic int_line;
	logic txd_r;

	assign pins = {general_pin_five, lin_rxd};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_sync
			// two stages against metastability on the pins
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					pin_s1_r[gi] <= 1'b1;
					pin_s2_r[gi] <= 1'b1;
				end
				else
				begin
					pin_s1_r[gi] <= pins[gi];
					pin_s2_r[gi] <= pin_s1_r[gi];
				end
			end
		end
	endgenerate

	// reserved select codes leave the receiver idle
	assign ext_rx = in_sel == `ULC_SEL_LIN ? pin_s2_r[0] :
		(in_sel == `ULC_SEL_GP5 ? pin_s2_r[1] : 1'b1);
	assign int_line = lcr_r[`ULC_LC_BRK] ? 1'b0 : tx_ser_r;
	assign rif.rx_in = loop ? int_line : ext_rx;
	assign rif.tick = tick;
	assign rif.cfg = lcr_frame;

	// loopback parks the pin high, break forces it low
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			txd_r <= 1'b1;
		else
			txd_r <= loop ? 1'b1 : int_line;
	end
	assign txd = txd_r;

	ulc_rx ulc_rx_inst
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.rif(rif)
	);

	// ****************************************
	// checks
	// ****************************************
	chk_break_pin: assert property (@(posedge hclk) disable iff (!hresetn)
		($past(lcr_r[`ULC_LC_BRK]) && !$past(loop)) |-> !txd)
		else $error("break did not hold the pin low");
	chk_loop_pin: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(loop) |-> txd)
		else $error("loopback did not hold the pin high");
	chk_status_reset: assert property (@(posedge hclk)
		$rose(hresetn) |-> stat == `ULC_STAT_RESET)
		else $error("line status reset value wrong");
	chk_div_route: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && divisor_latch_access && addr_r == `ULC_ADDR_DATA)
		|=> (dll_r == $past(hwdata[7:0]) && $stable(thr_r)))
		else $error("divisor low not reached under latch access");
	chk_thr_route: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_en && !divisor_latch_access && addr_r == `ULC_ADDR_DATA)
		|=> (thr_full_r && $stable(dll_r)))
		else $error("transmit holding not reached");
	chk_stick_par: assert property (@(posedge hclk) disable iff (!hresetn)
		(tx_st_r == ST_PAR && tx_cfg_r.sp) |-> tx_ser_r == tx_cfg_r.even_parity_select)
		else $error("stick parity value wrong");
	chk_stop_len: assert property (@(posedge hclk) disable iff (!hresetn)
		(tx_st_r == ST_STOP && $past(tx_st_r) != ST_STOP) |-> stop_len_r ==
		(!tx_cfg_r.stb ? `ULC_STOP_ONE : (tx_cfg_r.word_length_select == 2'h0 ?
		`ULC_STOP_ONEHALF : `ULC_STOP_TWO)))
		else $error("stop length does not match framing");
	chk_cfg_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(tx_st_r != ST_IDLE && $past(tx_st_r) != ST_IDLE) |-> $stable(tx_cfg_r))
		else $error("framing changed inside a character");
	chk_pen_skip: assert property (@(posedge hclk) disable iff (!hresetn)
		(tx_st_r == ST_DATA && !tx_cfg_r.parity_enable) |=> tx_st_r != ST_PAR)
		else $error("parity sent while disabled");
	chk_rx_mux: assert property (@(posedge hclk) disable iff (!hresetn)
		(!loop && in_sel == `ULC_SEL_LIN && $past(hresetn, 2))
		|-> rif.rx_in == $past(lin_rxd, 2))
		else $error("receiver not fed from LIN input");
	chk_loop_feed: assert property (@(posedge hclk) disable iff (!hresetn)
		(loop && tx_st_r == ST_START) |-> !rif.rx_in)
		else $error("start bit not looped back");

endmodule

// ===== tb/ulc_peer.sv
// far-end serial device: sends on a receive pin and captures txd
`timescale 1ns/1ps
module ulc_peer
#(
	parameter int BITC = 32
)
(
	// clock
	input wire logic hclk,
	// serial lines
	input wire logic txd,
	output logic lin_rxd,
	output logic general_pin_five
);
	logic on_gp5 = 1'b0;
	int t0 = 0;
	int cyc = 0;
	// both lines idle high, as a biased line would rest
	initial
	begin
		lin_rxd = 1'b1;
		general_pin_five = 1'b1;
	end
	// cycle count, used to time start edges
	always @(posedge hclk)
		cyc <= cyc + 1;
	// one bit time on the chosen pin
	task automatic put(input logic v);
		if (on_gp5)
			general_pin_five <= v;
		else
			lin_rxd <= v;
		repeat (BITC) @(posedge hclk);
	endtask
	// one frame, lsb first, a single stop bit
	task automatic send(input logic [7:0] d, input int nb,
		input logic parity_enable, input logic pb);
		put(1'b0);
		for (int i = 0; i < nb; i++)
			put(d[i]);
		if (parity_enable)
			put(pb);
		put(1'b1);
	endtask
	// bounded wait for a start bit, then sample at bit middles
	task automatic grab(input int nb, input logic parity_enable,
		output logic [7:0] d, output logic pb, output logic ok);
		int n;
		n = 0;
		d = 8'h00;
		pb = 1'b0;
		while (txd !== 1'b1)
			@(posedge hclk);
		while (txd !== 1'b0 && n < 700)
		begin
			@(posedge hclk);
			n++;
		end
		ok = (txd === 1'b0);
		t0 = cyc;
		if (!ok)
			return;
		repeat (BITC / 2) @(posedge hclk);
		for (int i = 0; i < nb; i++)
		begin
			repeat (BITC) @(posedge hclk);
			d[i] = txd;
		end
		if (parity_enable)
		begin
			repeat (BITC) @(posedge hclk);
			pb = txd;
		end
	endtask
endmodule

// ===== tb/tb_uart_line_control.sv
// self-checking bench for the uart line control block
`timescale 1ns/1ps
`include "ulc_defs.svh"
module tb_uart_line_control;
	// ****************
	// bench signals
	// ****************
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic lin_rxd;
	logic gp5;
	logic txd;
	logic [31:0] rv;
	logic [7:0] g;
	logic pb;
	logic ok;
	int n_fail = 0;
	int checks_done = 0;
	// 20 MHz clock
	always #25 hclk = ~hclk;
	// single slave, so hreadyout is the bus hready
	ulc_top ulc_top_inst(.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .lin_rxd(lin_rxd),
		.general_pin_five(gp5), .txd(txd));
	ulc_peer ulc_peer_inst(.hclk(hclk), .txd(txd), .lin_rxd(lin_rxd),
		.general_pin_five(gp5));
	// compare and count
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one word transfer; each phase held until hready is seen high
	// at a rising edge; called just after a rising edge
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [7:0] wd);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		rv = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rdc(input string nm, input logic [31:0] a, e);
		bus(a, 1'b0, 8'h00);
		chk(nm, rv, e);
	endtask
	// poll until the transmitter is fully empty
	task automatic idle();
		rv = 32'h0;
		while (rv[6] !== 1'b1)
			bus(`ULC_ADDR_STAT, 1'b0, 8'h00);
	endtask
	function automatic logic [7:0] msk(input logic [7:0] lc);
		return 8'hFF >> (2'h3 - lc[1:0]);
	endfunction
	// stick wins; else even gives xor of data, odd its inverse
	function automatic logic par(input logic [7:0] d, lc);
		if (lc[5])
			return lc[4];
		return ^(d & msk(lc)) ^ ~lc[4];
	endfunction
	// ****************
	// scenarios
	// ****************
	task automatic t_regs();
		rdc("line ctl", `ULC_ADDR_LCR, 32'h00);
		rdc("input ctl", `ULC_ADDR_ICR, 32'h00);
		wr(`ULC_ADDR_STAT, 8'h1F);
		chk("okay resp", hresp, 1'b0);
		rdc("status", `ULC_ADDR_STAT, 32'h60);
		rdc("unmapped", 32'hFFFF0720, 32'h00);
	endtask
	// divisor banking; a divisor write must not start a character
	task automatic t_bank();
		wr(`ULC_ADDR_LCR, 8'h80);
		wr(`ULC_ADDR_DATA, 8'h01);
		wr(`ULC_ADDR_IER, 8'h00);
		wr(`ULC_ADDR_CDIV, 8'h00);
		rdc("div low", `ULC_ADDR_DATA, 32'h01);
		rdc("no tx", `ULC_ADDR_STAT, 32'h60);
		wr(`ULC_ADDR_LCR, 8'h00);
		wr(`ULC_ADDR_IER, 8'h05);
		rdc("rx hold", `ULC_ADDR_DATA, 32'h00);
		rdc("int en", `ULC_ADDR_IER, 32'h05);
		wr(`ULC_ADDR_LCR, 8'h80);
		rdc("div high", `ULC_ADDR_IER, 32'h00);
	endtask
	// break must win over a queued character
	task automatic t_brk();
		int ones;
		ones = 0;
		wr(`ULC_ADDR_LCR, 8'h43);
		wr(`ULC_ADDR_DATA, 8'hFF);
		repeat (400)
		begin
			@(posedge hclk);
			ones += (txd !== 1'b0);
		end
		chk("break low", ones, 0);
		wr(`ULC_ADDR_LCR, 8'h03);
		idle();
		chk("break off", txd, 1'b1);
	endtask
	// two queued characters; framing changed during the first
	task automatic t_tx(input logic [7:0] lc, d);
		int nb;
		int ex;
		int t1;
		int gap;
		nb = 5 + lc[1:0];
		ex = (1 + nb + lc[3]) * 32 + (lc[2] ? (nb == 5 ? 48 : 64) : 32);
		wr(`ULC_ADDR_LCR, lc);
		fork
			ulc_peer_inst.grab(nb, lc[3], g, pb, ok);
			begin
				wr(`ULC_ADDR_DATA, d);
				wr(`ULC_ADDR_DATA, ~d);
				wr(`ULC_ADDR_LCR, lc ^ 8'h0C);
			end
		join
		chk("tx data", g, d & msk(lc));
		chk("tx parity", pb & lc[3], par(d, lc) & lc[3]);
		t1 = ulc_peer_inst.t0;
		ulc_peer_inst.grab(nb, 1'b0, g, pb, ok);
		gap = ulc_peer_inst.t0 - t1;
		chk("frame time", gap >= ex && gap <= ex + 3, 1'b1);
		idle();
	endtask
	// clock divider of one doubles the bit time to 64 clocks;
	// all-ones data so the second wait only sees the next start
	task automatic t_cdiv();
		int t1;
		int gap;
		wr(`ULC_ADDR_LCR, 8'h00);
		wr(`ULC_ADDR_CDIV, 8'h01);
		rdc("clk div", `ULC_ADDR_CDIV, 32'h01);
		fork
			ulc_peer_inst.grab(5, 1'b0, g, pb, ok);
			begin
				wr(`ULC_ADDR_DATA, 8'h1F);
				wr(`ULC_ADDR_DATA, 8'h1F);
			end
		join
		t1 = ulc_peer_inst.t0;
		ulc_peer_inst.grab(5, 1'b0, g, pb, ok);
		gap = ulc_peer_inst.t0 - t1;
		// seven bits of 64 clocks, start bit phase varies by a tick
		chk("slow frame", gap >= 446 && gap <= 449, 1'b1);
		idle();
		wr(`ULC_ADDR_CDIV, 8'h00);
	endtask
	// one received character, parity optionally corrupted
	task automatic t_rx(input logic [7:0] lc, d, input logic flip);
		wr(`ULC_ADDR_LCR, lc);
		ulc_peer_inst.send(d, 5 + lc[1:0], lc[3], par(d, lc) ^ flip);
		rdc("rx stat", `ULC_ADDR_STAT, {29'h0C, flip, 2'h1});
		rdc("rx data", `ULC_ADDR_DATA, d & msk(lc));
	endtask
	// receiver source switched to pin five; lin must then be ignored
	task automatic t_sel();
		wr(`ULC_ADDR_ICR, 8'h80);
		rdc("sel read", `ULC_ADDR_ICR, 32'h80);
		ulc_peer_inst.send(8'h5A, 8, 1'b0, 1'b0);
		rdc("lin ignored", `ULC_ADDR_STAT, 32'h60);
		ulc_peer_inst.on_gp5 = 1'b1;
		t_rx(8'h03, 8'hA5, 1'b0);
		ulc_peer_inst.on_gp5 = 1'b0;
		wr(`ULC_ADDR_ICR, 8'h00);
	endtask
	task automatic t_loop();
		wr(`ULC_ADDR_ICR, 8'h10);
		wr(`ULC_ADDR_LCR, 8'h03);
		fork
			ulc_peer_inst.grab(8, 1'b0, g, pb, ok);
			wr(`ULC_ADDR_DATA, 8'h3C);
		join
		chk("pin high", ok, 1'b0);
		rdc("loop data", `ULC_ADDR_DATA, 32'h3C);
		wr(`ULC_ADDR_ICR, 8'h00);
	endtask
	// second start bit lands where a second stop bit would be
	task automatic t_stop1();
		wr(`ULC_ADDR_LCR, 8'h07);
		ulc_peer_inst.send(8'h11, 8, 1'b0, 1'b0);
		ulc_peer_inst.send(8'h96, 8, 1'b0, 1'b0);
		bus(`ULC_ADDR_STAT, 1'b0, 8'h00);
		chk("one stop", rv & 32'h0D, 32'h01);
		rdc("second char", `ULC_ADDR_DATA, 32'h96);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ****************
	// sequence and watchdog
	// ****************
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_bank();
		t_brk();
		t_tx(8'h00, 8'hA7);
		t_tx(8'h04, 8'h16);
		t_tx(8'h05, 8'h2B);
		t_tx(8'h1A, 8'h35);
		t_tx(8'h0B, 8'hC4);
		t_tx(8'h2B, 8'h81);
		t_tx(8'h3F, 8'h7E);
		t_cdiv();
		t_rx(8'h03, 8'hC5, 1'b0);
		t_rx(8'h1A, 8'h35, 1'b0);
		t_rx(8'h1A, 8'h35, 1'b1);
		t_rx(8'h08, 8'h16, 1'b1);
		t_rx(8'h39, 8'h2A, 1'b1);
		t_rx(8'h29, 8'h0D, 1'b0);
		t_sel();
		t_loop();
		t_stop1();
		give_verdict();
	end
	// cut a hang short well past the expected run length
	initial
	begin
		repeat (60000) @(posedge hclk);
		n_fail++;
		give_verdict();
	end
endmodule
